// >>> logic/output_compare_pwm.sv
// output compare unit: pwm with shadow duty, fault shutdown, delayed one-shot, pulse
`timescale 1ns/1ps
`default_nettype none
module output_compare_pwm
   import ocpwm_pkg::*;
#(
   parameter int unsigned UNIT_INDEX = 1
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // classic wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // time bases, same clock domain
   input wire ocpwm_pkg::timebase_t timer_a_i,
   input wire ocpwm_pkg::timebase_t timer_b_i,
   // dma channel write port
   input wire ocpwm_pkg::dma_wr_t dma_i,
   // power state and general purpose pin latch
   input wire logic cpu_idle_i,
   input wire logic gpio_latch_i,
   input wire logic gpio_oe_i,
   // fault pins from outside
   input wire logic fault_input_a_n_i,
   input wire logic fault_input_b_n_i,
   // compare output pin and event
   output logic compare_output_pin_o,
   output logic compare_output_pin_oe_o,
   output logic compare_irq_flag_o
);
   import ocpwm_pkg::*;

   logic [15:0] control_q, control_d;
   logic [15:0] primary_q, primary_d;
   logic [15:0] secondary_q, secondary_d;
   logic pin_q, pin_d;
   logic oe_q, oe_d;
   logic irq_q, irq_d;
   logic flt_q, flt_d;
   logic armed_q, armed_d;
   logic done_q, done_d;
   logic ack_q;
   logic [31:0] rdata_q;
   logic [1:0] fa_sync_q, fb_sync_q;

   // fault pins are asynchronous; second stage only is read
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         fa_sync_q <= 2'h3;
         fb_sync_q <= 2'h3;
      end else begin
         fa_sync_q <= {fa_sync_q[0], fault_input_a_n_i};
         fb_sync_q <= {fb_sync_q[0], fault_input_b_n_i};
      end
   end

   wire mode_t mode = mode_t'(control_q[MODE_LSB +: 3]);
   wire tbsel = control_q[TBSEL_BIT];
   wire timebase_t tb = tbsel ? timer_b_i : timer_a_i;
   wire fault_n = (UNIT_INDEX <= 4) ? fa_sync_q[1] : fb_sync_q[1];
   wire halted = control_q[IDLE_BIT] & cpu_idle_i;
   wire is_pwm = (mode == MODE_PWM) || (mode == MODE_PWMF);
   wire is_dp = (mode == MODE_DELAY1) || (mode == MODE_PULSE);
   wire enabled = (mode != MODE_OFF);
   wire match_p = (tb.count == primary_q);
   wire match_s = (tb.count == secondary_q);
   wire roll = tb.rollover & ~halted;

   // bus decode
   wire bus_req = wb_cyc_i & wb_stb_i & ~ack_q;
   wire bus_wr = bus_req & wb_we_i;
   wire lo_en = wb_sel_i[0];
   wire hi_en = wb_sel_i[1];
   wire wr_ctl = bus_wr & (wb_adr_i == OFF_CONTROL);
   // dma wins only for the register it addresses; a bus write to the other one still lands
   wire dma_pri = dma_i.wr & ~dma_i.sel_secondary;
   wire dma_sec = dma_i.wr & dma_i.sel_secondary;
   wire wr_pri = (bus_wr & (wb_adr_i == OFF_PRIMARY)) | dma_pri;
   wire wr_sec = (bus_wr & (wb_adr_i == OFF_SECONDARY)) | dma_sec;
   wire irq_clr = bus_wr & (wb_adr_i == OFF_STATUS) & lo_en & wb_dat_i[IRQF_BIT];
   wire [15:0] bus_lane = {hi_en ? wb_dat_i[15:8] : 8'h00, lo_en ? wb_dat_i[7:0] : 8'h00};

   function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] nw,
                                         input logic lo, input logic hi);
      merge = {hi ? nw[15:8] : old[15:8], lo ? nw[7:0] : old[7:0]};
   endfunction

   wire [15:0] ctl_w = merge(control_q, bus_lane, lo_en, hi_en);
   wire [2:0] new_mode = ctl_w[MODE_LSB +: 3];
   wire mode_written = wr_ctl & lo_en;
   wire new_pwm = (new_mode == MODE_PWM) | (new_mode == MODE_PWMF);
   wire fault_now = (mode == MODE_PWMF) & ~fault_n & ~flt_q;
   // rewriting mode clears the latched fault only once the pin has recovered
   wire flt_release = mode_written & fault_n;

   always_comb begin
      control_d = control_q;
      if (wr_ctl) begin
         control_d = ctl_w & 16'h200f;
         control_d[FLT_BIT] = control_q[FLT_BIT];
      end
      control_d[FLT_BIT] = flt_d;
   end

   always_comb begin
      primary_d = primary_q;
      secondary_d = secondary_q;
      if (wr_sec) begin
         secondary_d = dma_sec ? dma_i.data : merge(secondary_q, bus_lane, lo_en, hi_en);
      end
      if (wr_pri && !is_pwm) begin
         primary_d = dma_pri ? dma_i.data : merge(primary_q, bus_lane, lo_en, hi_en);
      end
      if (is_pwm && roll) begin
         primary_d = secondary_q;
      end
   end

   always_comb begin
      pin_d = pin_q;
      oe_d = oe_q;
      armed_d = armed_q;
      done_d = done_q;
      flt_d = flt_q;
      irq_d = irq_q;
      // a clear loses to a set in the same cycle and is refused while the fault is latched
      if (irq_clr && !flt_q) begin
         irq_d = 1'b0;
      end
      if (mode_written) begin
         // entering a mode: pwm starts from the primary it will hold next, delay/pulse start low
         pin_d = new_pwm ? (primary_d != COMPARE_RST) : 1'b0;
         oe_d = (new_mode != MODE_OFF);
         armed_d = 1'b0;
         done_d = 1'b0;
      end else if (halted || !enabled) begin
         oe_d = enabled & ~flt_q;
      end else if (is_pwm) begin
         if (roll) begin
            pin_d = (secondary_q != COMPARE_RST);
         end else if (match_p) begin
            pin_d = 1'b0;
         end
      end else if (is_dp && !done_q) begin
         if (roll) begin
            armed_d = 1'b1;
         end
         // zero primary only matches from the first rollover on
         if (match_p && (primary_q != COMPARE_RST || armed_q || roll)) begin
            pin_d = 1'b1;
         end
         if (match_s && pin_q) begin
            pin_d = 1'b0;
            irq_d = 1'b1;
            done_d = (mode == MODE_DELAY1);
         end
      end
      if (fault_now) begin
         flt_d = 1'b1;
         irq_d = 1'b1;
         oe_d = 1'b0;
      end else if (flt_release) begin
         flt_d = 1'b0;
      end
      if (flt_d) begin
         oe_d = 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         control_q <= CONTROL_RST;
         primary_q <= COMPARE_RST;
         secondary_q <= COMPARE_RST;
         pin_q <= 1'b0;
         oe_q <= 1'b0;
         irq_q <= 1'b0;
         flt_q <= 1'b0;
         armed_q <= 1'b0;
         done_q <= 1'b0;
      end else begin
         control_q <= control_d;
         primary_q <= primary_d;
         secondary_q <= secondary_d;
         pin_q <= pin_d;
         oe_q <= oe_d;
         irq_q <= irq_d;
         flt_q <= flt_d;
         armed_q <= armed_d;
         done_q <= done_d;
      end
   end

   wire [15:0] rd_sel = (wb_adr_i == OFF_CONTROL) ? control_q :
                        (wb_adr_i == OFF_PRIMARY) ? primary_q :
                        (wb_adr_i == OFF_SECONDARY) ? secondary_q :
                        (wb_adr_i == OFF_STATUS) ? {15'h0000, irq_q} : 16'h0000;

   // one wait state: ack one cycle after the request, dropped the next cycle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
      end else begin
         ack_q <= bus_req;
         rdata_q <= {16'h0000, rd_sel};
      end
   end

   // pin mux: disabled unit hands the pin back to the general purpose latch
   logic out_q, out_oe_q;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         out_q <= 1'b0;
         out_oe_q <= 1'b0;
      end else begin
         out_q <= enabled ? pin_d : gpio_latch_i;
         out_oe_q <= enabled ? oe_d : gpio_oe_i;
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_dat_o = rdata_q;
   assign compare_output_pin_o = out_q;
   assign compare_output_pin_oe_o = out_oe_q;
   assign compare_irq_flag_o = irq_q;

   AST_PWM_ROLL_LOAD: assert property (@(posedge clk_i) disable iff (rst_i)
      (is_pwm && roll && !mode_written) |=> (primary_q == $past(secondary_q)))
      else $error("primary not loaded from secondary at rollover");
   AST_PWM_MATCH_LOW: assert property (@(posedge clk_i) disable iff (rst_i)
      (is_pwm && !roll && match_p && !mode_written && !halted) |=> !pin_q)
      else $error("pin not low after pwm match");
   AST_PWM_ROLL_PIN: assert property (@(posedge clk_i) disable iff (rst_i)
      (is_pwm && roll && !mode_written) |=> (pin_q == (primary_q != 16'h0000)))
      else $error("pin level after rollover wrong");
   AST_PWM_HOLD_PRIMARY: assert property (@(posedge clk_i) disable iff (rst_i)
      (is_pwm && !roll) |=> $stable(primary_q))
      else $error("primary changed between rollovers");
   AST_ENTER_PWM: assert property (@(posedge clk_i) disable iff (rst_i)
      (mode_written && new_pwm) |=> (pin_q == (primary_q != 16'h0000)))
      else $error("pin wrong on pwm enable");
   AST_FAULT_TRISTATE: assert property (@(posedge clk_i) disable iff (rst_i)
      fault_now |=> (!oe_q && flt_q && irq_q) ##1 !compare_output_pin_oe_o)
      else $error("fault did not tri-state pin");
   AST_FAULT_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
      (flt_q && !flt_release) |=> (flt_q && irq_q && !oe_q))
      else $error("fault released without mode rewrite");
   AST_ZERO_FIRST_CYCLE: assert property (@(posedge clk_i) disable iff (rst_i)
      (is_dp && !armed_q && !roll && primary_q == 16'h0000 && !pin_q && !mode_written) |=> !pin_q)
      else $error("zero compare matched in first timer cycle");
   AST_ZERO_SECOND_CYCLE: assert property (@(posedge clk_i) disable iff (rst_i)
      (is_dp && !done_q && roll && match_p && primary_q == 16'h0000 && secondary_q != 16'h0000
       && !mode_written) |=> pin_q)
      else $error("zero compare missed in second timer cycle");
   AST_OFF_RELEASE: assert property (@(posedge clk_i) disable iff (rst_i)
      !enabled && !mode_written |=> (compare_output_pin_oe_o == $past(gpio_oe_i)))
      else $error("disabled unit did not return pin");
   AST_ACK_ONE: assert property (@(posedge clk_i) disable iff (rst_i)
      wb_ack_o |=> !wb_ack_o)
      else $error("ack held more than one cycle");
endmodule
`default_nettype wire

// >>> common/ocpwm_pkg.sv
// package: register map, field layout and mode codes for the output compare pwm unit
package ocpwm_pkg;
   localparam int unsigned DATA_W = 16;
   // word-aligned byte offsets on the bus
   localparam logic [3:0] OFF_CONTROL = 4'h0;
   localparam logic [3:0] OFF_PRIMARY = 4'h4;
   localparam logic [3:0] OFF_SECONDARY = 4'h8;
   localparam logic [3:0] OFF_STATUS = 4'hc;
   // control and status field positions
   localparam int unsigned MODE_LSB = 0;
   localparam int unsigned TBSEL_BIT = 3;
   localparam int unsigned FLT_BIT = 4;
   localparam int unsigned IDLE_BIT = 13;
   localparam int unsigned IRQF_BIT = 0;
   localparam logic [15:0] CONTROL_RST = 16'h0000;
   localparam logic [15:0] COMPARE_RST = 16'h0000;
   typedef enum logic [2:0] {
      MODE_OFF = 3'h0,
      MODE_LOW1 = 3'h1,
      MODE_HIGH1 = 3'h2,
      MODE_TOGGLE = 3'h3,
      MODE_DELAY1 = 3'h4,
      MODE_PULSE = 3'h5,
      MODE_PWM = 3'h6,
      MODE_PWMF = 3'h7
   } mode_t;
   // selected time base as seen by the unit
   typedef struct packed {
      logic [15:0] count;
      logic [15:0] period;
      logic rollover;
   } timebase_t;
   // generic write port for a dma channel
   typedef struct packed {
      logic wr;
      logic sel_secondary;
      logic [15:0] data;
   } dma_wr_t;
endpackage

// >>> tb/load_model.sv
// external load: pull-down on the compare pad and two fault switches
`timescale 1ns/1ps
`default_nettype none
module load_model (
   // pad side
   input wire logic pin_i,
   input wire logic oe_i,
   input wire logic [1:0] trip_i,
   // fault switches and pad level
   output logic fault_input_a_n_o,
   output logic fault_input_b_n_o,
   output logic pad_o
);
   // pull-down, so a tri-stated pad reads low and never a stale level
   assign pad_o = oe_i ? pin_i : 1'b0;
   // switches open again once the fault is gone; pull-ups hold the lines high
   assign fault_input_a_n_o = ~trip_i[0];
   assign fault_input_b_n_o = ~trip_i[1];
endmodule
`default_nettype wire

// >>> tb/tb.sv
// testbench: pwm duty, shadow load, time bases, dma, fault shutdown
`timescale 1ns/1ps
`default_nettype none
module tb;
   import ocpwm_pkg::*;
   typedef struct {int kind; logic [31:0] v;} note_t;
   localparam logic [15:0] PA = 16'h0007;
   localparam logic [15:0] PB = 16'h000b;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, pin, oe, irq, pad, fa_n, fb_n, roll_s;
   logic [3:0] adr = 4'h0;
   logic [31:0] wdat = 32'h0, rdat, e;
   logic [15:0] cnt_a = 16'h0, cnt_b = 16'h0, v;
   logic roll_a = 1'b0, roll_b = 1'b0, run = 1'b0, msel = 1'b0, idle = 1'b0;
   logic meas = 1'b0, smp = 1'b0, gl = 1'b0, go = 1'b0;
   logic [1:0] trip = 2'h0;
   logic [7:0] rnd = 8'h48;
   dma_wr_t dma = '0;
   note_t q[$];
   string nm[3] = '{"rdata", "duty", "pad"};
   int fails = 0, num_checks = 0, cyc_n = 0, hi = 0;
   always #2.5 clk_i = ~clk_i;
   output_compare_pwm u_output_compare_pwm (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .timer_a_i({cnt_a, PA, roll_a}), .timer_b_i({cnt_b, PB, roll_b}), .dma_i(dma),
      .cpu_idle_i(idle), .gpio_latch_i(gl), .gpio_oe_i(go), .fault_input_a_n_i(fa_n),
      .fault_input_b_n_i(fb_n), .compare_output_pin_o(pin),
      .compare_output_pin_oe_o(oe), .compare_irq_flag_o(irq));
   load_model u_load_model (.pin_i(pin), .oe_i(oe), .trip_i(trip),
      .fault_input_a_n_o(fa_n), .fault_input_b_n_o(fb_n), .pad_o(pad));
   assign roll_s = msel ? roll_b : roll_a;
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // two free-running time bases; timer a only counts once started
   always @(posedge clk_i) begin
      if (run) begin
         cnt_a <= (cnt_a == PA) ? 16'h0 : cnt_a + 16'h1;
         roll_a <= (cnt_a == PA);
      end else begin
         // a stopped time base raises no rollover
         roll_a <= 1'b0;
      end
      cnt_b <= (cnt_b == PB) ? 16'h0 : cnt_b + 16'h1;
      roll_b <= (cnt_b == PB);
      cyc_n <= cyc_n + 1;
      if (cyc_n == 20000) begin
         fails++;
         print_verdict();
      end
   end
   task automatic check(input int k, input logic [31:0] seen);
      note_t n;
      n = q.pop_front();
      num_checks++;
      if (n.kind != k || n.v !== seen) begin
         fails++;
         $display("unexpected %s: expected %h seen %h", nm[k], n.v, seen);
      end
   endtask
   // monitor: read data at ack, pad snapshots, high count over one whole period
   always @(posedge clk_i) begin
      if (ack === 1'b1 && !we) check(0, rdat);
      if (smp) check(2, {29'h0, irq, oe, pad});
      if (roll_s) begin
         if (meas) check(1, 32'(hi));
         hi = 0;
      end
      hi += (pin === 1'b1 && oe === 1'b1) ? 1 : 0;
   end
   task automatic wb(input logic w, input logic [3:0] a, input logic [15:0] d);
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= {16'h0, d};
      do @(posedge clk_i); while (ack !== 1'b1);
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] x);
      q.push_back('{0, x});
      wb(1'b0, a, 16'h0);
   endtask
   task automatic sample(input logic [31:0] x);
      q.push_back('{2, x});
      // fault pins need two sync stages, then the flag and output registers load on the same edge before the pad shows it
      repeat (4) @(posedge clk_i);
      smp <= 1'b1;
      @(posedge clk_i);
      smp <= 1'b0;
   endtask
   task automatic wroll();
      do @(posedge clk_i); while (!roll_s);
   endtask
   // one roll loads the shadow, the period after the next roll is measured whole
   task automatic duty(input logic [31:0] x);
      q.push_back('{1, x});
      wroll();
      wroll();
      meas <= 1'b1;
      wroll();
      meas <= 1'b0;
   endtask
   initial begin
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(OFF_CONTROL, 32'h0);
      rd(OFF_SECONDARY, 32'h0);
      rd(OFF_STATUS, 32'h0);
      rd(4'h2, 32'h0);
      rnd = lfsr(rnd);
      gl <= rnd[0];
      go <= 1'b1;
      sample({30'h1, rnd[0]});
      wb(1'b1, OFF_PRIMARY, 16'h0003);
      wb(1'b1, OFF_SECONDARY, 16'h0005);
      wb(1'b1, OFF_CONTROL, {13'h0, MODE_PWM});
      sample(32'h3);
      wb(1'b1, OFF_PRIMARY, 16'h0009);
      rd(OFF_PRIMARY, 32'h3);
      run <= 1'b1;
      duty(32'h5);
      wroll();
      wb(1'b1, OFF_SECONDARY, 16'h0000);
      rd(OFF_PRIMARY, 32'h5);
      for (int i = 0; i < 4; i++) begin
         rnd = lfsr(rnd);
         v = (i == 0) ? 16'h0 : (i == 1) ? PA : (i == 2) ? 16'h0009 : {13'h0, rnd[2:0]};
         e = (v > PA) ? 32'(PA) + 32'h1 : 32'(v);
         if (i[0]) begin
            @(posedge clk_i);
            dma <= '{1'b1, 1'b1, v};
            @(posedge clk_i);
            dma <= '0;
         end else begin
            wb(1'b1, OFF_SECONDARY, v);
         end
         duty(e);
      end
      msel <= 1'b1;
      wb(1'b1, OFF_CONTROL, {12'h0, 1'b1, MODE_PWM});
      wb(1'b1, OFF_SECONDARY, 16'h0004);
      duty(32'h4);
      msel <= 1'b0;
      wb(1'b1, OFF_CONTROL, {13'h0, MODE_PWMF});
      wb(1'b1, OFF_SECONDARY, 16'h0003);
      trip <= 2'b10;
      duty(32'h3);
      trip <= 2'b01;
      sample(32'h4);
      rd(OFF_CONTROL, 32'h17);
      wb(1'b1, OFF_STATUS, 16'h0001);
      rd(OFF_STATUS, 32'h1);
      trip <= 2'b00;
      sample(32'h4);
      wb(1'b1, OFF_CONTROL, {13'h0, MODE_PWMF});
      duty(32'h3);
      wb(1'b1, OFF_STATUS, 16'h0001);
      // halted unit keeps the level it was enabled with, so the whole period stays high
      idle <= 1'b1;
      wb(1'b1, OFF_CONTROL, {2'h0, 1'b1, 10'h0, MODE_PWM});
      duty(32'(PA) + 32'h1);
      idle <= 1'b0;
      wb(1'b1, OFF_CONTROL, {13'h0, MODE_OFF});
      sample({30'h1, gl});
      @(posedge clk_i);
      dma <= '{1'b0, 1'b0, 16'h0000};
      dma.wr <= 1'b1;
      @(posedge clk_i);
      dma <= '0;
      rd(OFF_PRIMARY, 32'h0);
      wb(1'b1, OFF_SECONDARY, 16'h0003);
      // freeze timer a at count zero so the first cycle offers a zero match
      do @(posedge clk_i); while (cnt_a != PA);
      run <= 1'b0;
      wb(1'b1, OFF_CONTROL, {13'h0, MODE_PULSE});
      sample(32'h2);
      q.push_back('{1, 32'h3});
      run <= 1'b1;
      wroll();
      meas <= 1'b1;
      wroll();
      meas <= 1'b0;
      print_verdict();
   end
endmodule
`default_nettype wire
